// File: pmer_pkg.sv
// Shared constants, register map and field layout of the event routing block
package pmer_pkg;
	// Sizes
	localparam int NREG = 29;
	localparam int NGPIO = 11;
	localparam int NRAIL = 10;
	localparam int NMSK = 17;
	localparam int NEV = NMSK * 8;
	localparam int NTRIG = 4;
	localparam int NPGIN = 2 * NRAIL + 3;

	// Register indices, also the register pointer value on the serial link
	localparam logic [7:0] R_RAIL_A = 8'h00;
	localparam logic [7:0] R_RAIL_B = 8'h01;
	localparam logic [7:0] R_RAIL_C = 8'h02;
	localparam logic [7:0] R_TRIG_A = 8'h03;
	localparam logic [7:0] R_TRIG_B = 8'h04;
	localparam logic [7:0] R_GATE_A = 8'h05;
	localparam logic [7:0] R_SW_A = 8'h08;
	localparam logic [7:0] R_SUPMON = 8'h0D;
	localparam logic [7:0] R_FALL = 8'h0E;
	localparam logic [7:0] R_RISE = 8'h0F;
	localparam logic [7:0] R_PINHI = 8'h10;
	localparam logic [7:0] R_FSMF = 8'h14;
	localparam logic [7:0] R_PG_A = 8'h19;
	localparam logic [7:0] R_PG_B = 8'h1A;
	localparam logic [7:0] R_PG_C = 8'h1B;
	localparam logic [7:0] R_PG_D = 8'h1C;
	localparam logic [7:0] MSK_FIRST = R_SW_A;
	localparam logic [7:0] PEND_BASE = 8'h20;

	// Field codes
	localparam logic [1:0] GRP_NONE = 2'h0;
	localparam logic [1:0] GRP_MCU = 2'h1;
	localparam logic [1:0] GRP_SOC = 2'h2;
	localparam logic [1:0] TRG_IMM = 2'h0;
	localparam logic [1:0] TRG_ORD = 2'h1;
	localparam logic [1:0] TRG_MCU = 2'h2;
	localparam logic [1:0] TRG_SOC = 2'h3;

	// Field positions
	localparam int TRIG_MCU_LSB = 0;
	localparam int TRIG_SOC_LSB = 2;
	localparam int TRIG_OTH_LSB = 4;
	localparam int TRIG_SEV_LSB = 6;
	localparam int TRIG_MED_LSB = 0;
	localparam int SUP_OV_BIT = 0;
	localparam int SUP_UV_BIT = 1;
	localparam int FF_IMM = 0;
	localparam int FF_MCU = 1;
	localparam int FF_SOC = 2;
	localparam int FF_ORD = 3;
	localparam int PGD_POL_BIT = 4;
	localparam int PGD_WIN_BIT = 5;
	localparam int PINHI_RISE_LSB = 3;

	// Bit offsets of event groups inside the pending vector
	localparam int EV_FALL = (int'(R_FALL) - int'(MSK_FIRST)) * 8;
	localparam int EV_RISE = (int'(R_RISE) - int'(MSK_FIRST)) * 8;
	localparam int EV_PINHI = (int'(R_PINHI) - int'(MSK_FIRST)) * 8;
	localparam int EV_FSMF = (int'(R_FSMF) - int'(MSK_FIRST)) * 8;

	// Serial byte framing
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_FULL = 4'h8;

	// Nonvolatile defaults, index 28 first
	localparam logic [NREG-1:0][7:0] RST_VAL = {
		8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h3F, 8'h00, 8'h00, 8'h00,
		8'h08, 8'h04, 8'h05, 8'h3F, 8'hFF, 8'hFF, 8'h03,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h15, 8'h55, 8'h55, 8'h01, 8'h1E, 8'h05, 8'h96, 8'h5A};

	// Implemented bits of each register, index 28 first
	localparam logic [NREG-1:0][7:0] WR_MASK = {
		8'h3F, 8'h0F, 8'h01, 8'h0F,
		8'h01, 8'h3F, 8'h03, 8'h1F, 8'h0F,
		8'h3F, 8'h07, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'h03,
		8'h3F, 8'h3F, 8'h07, 8'h3F, 8'h3F,
		8'h3F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
endpackage : pmer_pkg

// File: pmer_cfg_if.sv
// Carrier between the control logic, register store and power-good combiner
`timescale 1ns/1ps
interface pmer_cfg_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic sup_clr;
	logic [7:0] rdata;
	logic [pmer_pkg::NREG-1:0][7:0] cfg;
	modport ctl (
		output wr_en,
		output addr,
		output wdata,
		output sup_clr,
		input rdata,
		input cfg
	);
	modport regs (
		input wr_en,
		input addr,
		input wdata,
		input sup_clr,
		output rdata,
		output cfg
	);
	modport pg (
		input cfg
	);
endinterface : pmer_cfg_if

// File: pmer_regs.sv
// Configuration register store with registered read data
`timescale 1ns/1ps
module pmer_regs (
	input wire logic clk,
	input wire logic resetn,
	pmer_cfg_if.regs bus
);
	typedef struct packed {
		logic [pmer_pkg::NREG-1:0][7:0] mem;
		logic [7:0] rdata;
	} pmer_regs_st_t;

	pmer_regs_st_t r;
	pmer_regs_st_t n;

	////////////////////////////////////////////////////////////////////////
	// Next state: write port, self-test unmask, read port
	always_comb begin
		n = r;
		n.rdata = 8'h00;
		if (bus.addr < pmer_pkg::NREG) begin
			n.rdata = r.mem[bus.addr[4:0]];
		end
		if (bus.wr_en && bus.addr < pmer_pkg::NREG) begin
			// Unused positions stay zero
			n.mem[bus.addr[4:0]] = bus.wdata &
				pmer_pkg::WR_MASK[bus.addr[4:0]];
		end
		if (bus.sup_clr) begin
			n.mem[pmer_pkg::R_SUPMON][pmer_pkg::SUP_OV_BIT] = 1'b0;
			n.mem[pmer_pkg::R_SUPMON][pmer_pkg::SUP_UV_BIT] = 1'b0;
		end
	end

	// State register, defaults load at reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r.mem <= pmer_pkg::RST_VAL;
			r.rdata <= 8'h00;
		end else begin
			r <= n;
		end
	end

	assign bus.rdata = r.rdata;
	assign bus.cfg = r.mem;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_write_lands: assert property (
		bus.wr_en && bus.addr == pmer_pkg::R_TRIG_A && !bus.sup_clr
		|=> r.mem[pmer_pkg::R_TRIG_A] == $past(bus.wdata))
		else $error("trigger map write not stored");
	a_unused_zero: assert property (
		bus.wr_en && bus.addr == pmer_pkg::R_RAIL_C
		|=> (r.mem[pmer_pkg::R_RAIL_C] & ~pmer_pkg::WR_MASK[pmer_pkg::R_RAIL_C])
			== 8'h00)
		else $error("unused bits took a write");
endmodule : pmer_regs

// File: pmer_power_good_output.sv
// Power-good combiner with source select, polarity and window mode
`timescale 1ns/1ps
module pmer_power_good_output (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [pmer_pkg::NRAIL-1:0] uv_ok,
	input wire logic [pmer_pkg::NRAIL-1:0] ov_ok,
	input wire logic tdie_ok,
	input wire logic [1:0] rst_ok,
	pmer_cfg_if.pg bus,
	output logic pg_out
);
	typedef struct packed {
		logic [pmer_pkg::NPGIN-1:0] sy1;
		logic [pmer_pkg::NPGIN-1:0] sy2;
		logic pg;
	} pmer_pg_st_t;

	pmer_pg_st_t r;
	pmer_pg_st_t n;
	logic [12:0] sel;
	logic [12:0] valid;
	logic pol;
	logic win;
	logic all_ok;

	////////////////////////////////////////////////////////////////////////
	// Source select bits: rails, die warning, two reset outputs
	assign sel = {bus.cfg[pmer_pkg::R_PG_D][3:0],
		bus.cfg[pmer_pkg::R_PG_C][3:0], bus.cfg[pmer_pkg::R_PG_B][0],
		bus.cfg[pmer_pkg::R_PG_A][3:0]};
	assign pol = bus.cfg[pmer_pkg::R_PG_D][pmer_pkg::PGD_POL_BIT];
	assign win = bus.cfg[pmer_pkg::R_PG_D][pmer_pkg::PGD_WIN_BIT];

	// Undervoltage always, overvoltage only in window mode
	assign valid = {r.sy2[pmer_pkg::NPGIN-1:2 * pmer_pkg::NRAIL],
		r.sy2[pmer_pkg::NRAIL-1:0] &
		(r.sy2[2 * pmer_pkg::NRAIL-1:pmer_pkg::NRAIL] |
		{pmer_pkg::NRAIL{~win}})};
	assign all_ok = &(~sel | valid);

	// Next state
	always_comb begin
		n = r;
		n.sy1 = {rst_ok, tdie_ok, ov_ok, uv_ok};
		n.sy2 = r.sy1;
		n.pg = pol ? ~all_ok : all_ok;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign pg_out = r.pg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_pg_none_sel: assert property (
		sel == 13'h0000 && !pol |=> pg_out)
		else $error("power good low with no source selected");
	a_pg_uv_only: assert property (
		sel == 13'h0001 && !pol && !win && r.sy2[0]
		|=> pg_out)
		else $error("overvoltage checked outside window mode");
endmodule : pmer_power_good_output

// File: pmer_top.sv
// Event routing and configuration block of the power management device
`timescale 1ns/1ps
module pmer_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [pmer_pkg::NGPIO-1:0] gpio_pin,
	input wire logic [pmer_pkg::NRAIL-1:0] rail_fault,
	input wire logic severe_fault,
	input wire logic medium_fault,
	input wire logic self_test_done,
	input wire logic [pmer_pkg::NEV-1:0] irq_event,
	input wire logic [pmer_pkg::NRAIL-1:0] mon_uv_ok,
	input wire logic [pmer_pkg::NRAIL-1:0] mon_ov_ok,
	input wire logic tdie_ok,
	input wire logic [1:0] rst_out_ok,
	output logic interrupt_request_pin_n,
	output logic power_good_output,
	output logic [pmer_pkg::NGPIO-1:0] pin_trigger_out,
	output logic [pmer_pkg::NTRIG-1:0] trigger_req
);
	localparam int SYNW = pmer_pkg::NGPIO + 2;

	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACKM, S_TX, S_ACKS} pmer_state_t;
	typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} pmer_phase_t;

	typedef struct packed {
		logic [SYNW-1:0] sy1;
		logic [SYNW-1:0] sy2;
		logic scl_p;
		logic sda_p;
		logic [pmer_pkg::NGPIO-1:0] gpio_p;
		pmer_state_t st;
		pmer_phase_t phase;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic sda_oe;
		logic sda_o;
		logic [pmer_pkg::NEV-1:0] pend;
		logic [pmer_pkg::NGPIO-1:0] gate_out;
		logic [pmer_pkg::NTRIG-1:0] trig;
		logic irq_n;
	} pmer_st_t;

	pmer_st_t r;
	pmer_st_t n;
	logic [pmer_pkg::NEV-1:0] irq_mask;
	logic [pmer_pkg::NEV-1:0] ev_valid;

	pmer_cfg_if cfg_bus ();

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Group code of rail i, four two-bit fields per register
	function automatic logic [1:0] grp_of(
		input logic [pmer_pkg::NREG-1:0][7:0] c,
		input int i
	);
		logic [7:0] rg;
		rg = c[pmer_pkg::R_RAIL_A + 8'(i / 4)];
		return rg[(i % 4) * 2 +: 2];
	endfunction : grp_of

	// One-hot request for a trigger code
	function automatic logic [pmer_pkg::NTRIG-1:0] trig_hot(
		input logic [1:0] code
	);
		return 4'h1 << code;
	endfunction : trig_hot

	// Mask registers laid out as one vector matching the pending bits
	function automatic logic [pmer_pkg::NEV-1:0] mask_vec(
		input logic [pmer_pkg::NREG-1:0][7:0] c
	);
		logic [pmer_pkg::NEV-1:0] v;
		v = '0;
		for (int k = 0; k < pmer_pkg::NMSK; k++) begin
			v[k * 8 +: 8] = c[pmer_pkg::MSK_FIRST + 8'(k)];
		end
		return v;
	endfunction : mask_vec

	// Gate enable and forced level of pin g, two bits per pin
	function automatic logic [1:0] gate_of(
		input logic [pmer_pkg::NREG-1:0][7:0] c,
		input int g
	);
		logic [7:0] rg;
		rg = c[pmer_pkg::R_GATE_A + 8'(g / 4)];
		return rg[(g % 4) * 2 +: 2];
	endfunction : gate_of

	assign irq_mask = mask_vec(cfg_bus.cfg);
	assign ev_valid = mask_vec(pmer_pkg::WR_MASK);

	////////////////////////////////////////////////////////////////////////
	// Submodules
	pmer_regs u_regs (
		.clk(clk),
		.resetn(resetn),
		.bus(cfg_bus)
	);

	pmer_power_good_output u_power_good_output (
		.clk(clk),
		.resetn(resetn),
		.uv_ok(mon_uv_ok),
		.ov_ok(mon_ov_ok),
		.tdie_ok(tdie_ok),
		.rst_ok(rst_out_ok),
		.bus(cfg_bus),
		.pg_out(power_good_output)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic [pmer_pkg::NGPIO-1:0] gpio;
		logic [pmer_pkg::NGPIO-1:0] rise;
		logic [pmer_pkg::NGPIO-1:0] fall;
		logic [pmer_pkg::NEV-1:0] ev;
		logic [pmer_pkg::NEV-1:0] clr;
		logic hit_mcu;
		logic hit_soc;
		logic hit_oth;
		logic [1:0] gb;
		logic [7:0] rdb;
		int k;
		scl = r.sy2[0];
		sda = r.sy2[1];
		gpio = r.sy2[SYNW-1:2];
		scl_rise = scl && !r.scl_p;
		scl_fall = !scl && r.scl_p;
		start = scl && r.scl_p && r.sda_p && !sda;
		stop = scl && r.scl_p && !r.sda_p && sda;
		rise = gpio & ~r.gpio_p;
		fall = ~gpio & r.gpio_p;
		ev = irq_event;
		clr = '0;
		hit_mcu = 1'b0;
		hit_soc = 1'b0;
		hit_oth = 1'b0;
		gb = 2'h0;
		k = int'(r.ptr) - int'(pmer_pkg::PEND_BASE);
		rdb = 8'h00;
		if (r.ptr < pmer_pkg::NREG) begin
			rdb = cfg_bus.rdata;
		end else if (k >= 0 && k < pmer_pkg::NMSK) begin
			rdb = r.pend[k * 8 +: 8];
		end

		n = r;
		cfg_bus.wr_en = 1'b0;
		cfg_bus.addr = r.ptr;
		cfg_bus.wdata = r.sh;
		cfg_bus.sup_clr = self_test_done;

		// Two-stage synchronisers for the link and pin inputs
		n.sy1 = {gpio_pin, sda_in, scl_in};
		n.sy2 = r.sy1;
		n.scl_p = scl;
		n.sda_p = sda;
		n.gpio_p = gpio;

		// Serial slave: receive, acknowledge, transmit
		case (r.st)
			S_IDLE: begin
				n.sda_oe = 1'b0;
			end
			S_RX: begin
				if (scl_rise) begin
					n.sh = {r.sh[6:0], sda};
					n.bitcnt = r.bitcnt + 4'h1;
				end else if (scl_fall && r.bitcnt == pmer_pkg::BIT_FULL) begin
					n.bitcnt = 4'h0;
					n.st = S_ACKM;
					n.sda_oe = 1'b1;
					if (r.phase == PH_ADDR) begin
						n.rw = r.sh[0];
						if (r.sh[7:1] != DEV_ADDR) begin
							n.st = S_IDLE;
							n.sda_oe = 1'b0;
						end
					end else if (r.phase == PH_REG) begin
						n.ptr = r.sh;
					end else begin
						cfg_bus.wr_en = 1'b1;
						if (k >= 0 && k < pmer_pkg::NMSK) begin
							clr[k * 8 +: 8] = r.sh;
						end
						n.ptr = r.ptr + 8'h01;
					end
				end
			end
			S_ACKM: begin
				if (scl_fall) begin
					n.sda_oe = 1'b0;
					n.st = S_RX;
					if (r.phase == PH_ADDR && r.rw) begin
						n.st = S_TX;
						n.sh = rdb;
						n.sda_oe = ~rdb[7];
					end else if (r.phase == PH_ADDR) begin
						n.phase = PH_REG;
					end else begin
						n.phase = PH_DATA;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					if (r.bitcnt == pmer_pkg::BIT_LAST) begin
						n.sda_oe = 1'b0;
						n.st = S_ACKS;
						n.ptr = r.ptr + 8'h01;
					end else begin
						n.sh = {r.sh[6:0], 1'b0};
						n.sda_oe = ~r.sh[6];
						n.bitcnt = r.bitcnt + 4'h1;
					end
				end
			end
			S_ACKS: begin
				if (scl_rise) begin
					n.nack = sda;
				end else if (scl_fall) begin
					n.bitcnt = 4'h0;
					if (!r.nack) begin
						n.st = S_TX;
						n.sh = rdb;
						n.sda_oe = ~rdb[7];
					end else begin
						n.st = S_IDLE;
					end
				end
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase
		if (start) begin
			n.st = S_RX;
			n.phase = PH_ADDR;
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
		end else if (stop) begin
			n.st = S_IDLE;
			n.sda_oe = 1'b0;
		end

		// Gated pin levels toward the sequencer
		for (int g = 0; g < pmer_pkg::NGPIO; g++) begin
			gb = gate_of(cfg_bus.cfg, g);
			n.gate_out[g] = gb[0] ? gb[1] : gpio[g];
		end

		// Rail faults routed through their group to a trigger
		for (int i = 0; i < pmer_pkg::NRAIL; i++) begin
			if (rail_fault[i]) begin
				if (grp_of(cfg_bus.cfg, i) == pmer_pkg::GRP_MCU) begin
					hit_mcu = 1'b1;
				end else if (grp_of(cfg_bus.cfg, i) == pmer_pkg::GRP_SOC) begin
					hit_soc = 1'b1;
				end else begin
					hit_oth = 1'b1;
				end
			end
		end
		n.trig = '0;
		if (hit_mcu) begin
			n.trig |= trig_hot(cfg_bus.cfg[pmer_pkg::R_TRIG_A]
				[pmer_pkg::TRIG_MCU_LSB +: 2]);
		end
		if (hit_soc) begin
			n.trig |= trig_hot(cfg_bus.cfg[pmer_pkg::R_TRIG_A]
				[pmer_pkg::TRIG_SOC_LSB +: 2]);
		end
		if (hit_oth) begin
			n.trig |= trig_hot(cfg_bus.cfg[pmer_pkg::R_TRIG_A]
				[pmer_pkg::TRIG_OTH_LSB +: 2]);
		end
		if (severe_fault) begin
			n.trig |= trig_hot(cfg_bus.cfg[pmer_pkg::R_TRIG_A]
				[pmer_pkg::TRIG_SEV_LSB +: 2]);
		end
		if (medium_fault) begin
			n.trig |= trig_hot(cfg_bus.cfg[pmer_pkg::R_TRIG_B]
				[pmer_pkg::TRIG_MED_LSB +: 2]);
		end

		// Internal events: pin edges and sequencer trigger requests
		ev[pmer_pkg::EV_FALL +: 8] |= fall[7:0];
		ev[pmer_pkg::EV_RISE +: 8] |= rise[7:0];
		ev[pmer_pkg::EV_PINHI +: 3] |= fall[10:8];
		ev[pmer_pkg::EV_PINHI + pmer_pkg::PINHI_RISE_LSB +: 3] |= rise[10:8];
		ev[pmer_pkg::EV_FSMF + pmer_pkg::FF_IMM] |= r.trig[pmer_pkg::TRG_IMM];
		ev[pmer_pkg::EV_FSMF + pmer_pkg::FF_MCU] |= r.trig[pmer_pkg::TRG_MCU];
		ev[pmer_pkg::EV_FSMF + pmer_pkg::FF_SOC] |= r.trig[pmer_pkg::TRG_SOC];
		ev[pmer_pkg::EV_FSMF + pmer_pkg::FF_ORD] |= r.trig[pmer_pkg::TRG_ORD];

		// Sticky pending bits; a new event wins over a clear
		n.pend = ((r.pend & ~clr) | ev) & ev_valid;
		n.irq_n = ~|(n.pend & ~irq_mask);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r <= '0;
			r.irq_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from flops
	assign sda_out = r.sda_o;
	assign sda_oe = r.sda_oe;
	assign interrupt_request_pin_n = r.irq_n;
	assign pin_trigger_out = r.gate_out;
	assign trigger_req = r.trig;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_test_done;
		self_test_done;
	endsequence

	a_irq_unmasked: assert property (
		|(r.pend & ~irq_mask) && $stable(irq_mask) |-> !interrupt_request_pin_n)
		else $error("unmasked pending event not on request pin");
	a_irq_masked_quiet: assert property (
		~|(r.pend & ~irq_mask) && $stable(irq_mask) |-> interrupt_request_pin_n)
		else $error("request pin low with nothing unmasked");
	a_gate_forced: assert property (
		cfg_bus.cfg[pmer_pkg::R_GATE_A][1:0] == 2'h1 |=> !pin_trigger_out[0])
		else $error("gated pin not forced low");
	a_edge_capture: assert property (
		r.sy2[2] && !r.gpio_p[0] |=> r.pend[pmer_pkg::EV_RISE])
		else $error("rising edge not captured");
	a_supply_unmask: assert property (
		s_test_done |=> cfg_bus.cfg[pmer_pkg::R_SUPMON][1:0] == 2'h0)
		else $error("supply masks not cleared after self test");
	a_group_route: assert property (
		rail_fault[0] && grp_of(cfg_bus.cfg, 0) == pmer_pkg::GRP_MCU &&
		cfg_bus.cfg[pmer_pkg::R_TRIG_A][1:0] == pmer_pkg::TRG_MCU
		|=> trigger_req[pmer_pkg::TRG_MCU])
		else $error("MCU group fault not routed");
	a_severe_map: assert property (
		severe_fault && cfg_bus.cfg[pmer_pkg::R_TRIG_A][7:6] == pmer_pkg::TRG_IMM
		|=> trigger_req[pmer_pkg::TRG_IMM])
		else $error("severe fault not mapped");
	a_trig_quiet: assert property (
		rail_fault == '0 && !severe_fault && !medium_fault |=> trigger_req == '0)
		else $error("trigger without a fault");
	a_fsm_event: assert property (
		trigger_req[pmer_pkg::TRG_ORD] && !cfg_bus.cfg[pmer_pkg::R_FSMF][3]
		|=> !interrupt_request_pin_n)
		else $error("orderly shutdown event did not interrupt");
endmodule : pmer_top

// File: pmer_host.sv
// Serial link host model that programs the device registers
`timescale 1ns/1ps
module pmer_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	logic ack;
	// Idle bus: clock high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Wait a number of falling clock edges
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	// One bit; data moves well after clock low so no false start or stop
	task automatic bit_io(input logic b, output logic s);
		w(2);
		sda_pull = ~b;
		w(5);
		scl = 1'b1;
		w(3);
		s = sda;
		w(2);
		scl = 1'b0;
	endtask : bit_io
	// Byte out MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] dv, input logic a,
		output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bit_io(dv[i], q[i]);
		bit_io(a, ack);
	endtask : xfer
	// Start or repeated start: data falls while clock is high
	task automatic start;
		w(2);
		sda_pull = 1'b0;
		w(5);
		scl = 1'b1;
		w(5);
		sda_pull = 1'b1;
		w(5);
		scl = 1'b0;
	endtask : start
	// Stop: data rises while clock is high
	task automatic stop;
		w(2);
		sda_pull = 1'b1;
		w(5);
		scl = 1'b1;
		w(5);
		sda_pull = 1'b0;
		w(5);
	endtask : stop
	////////////////////////////////////////////////////////////////////////
	// Register write, allowed at any time after startup
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		xfer(d, 1'b1, q);
		stop();
	endtask : wr
	// Register read through a repeated start, ended by a no-acknowledge
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q);
		xfer(8'hFF, 1'b1, d);
		stop();
	endtask : rd
endmodule : pmer_host

// File: test_pmic_event_routing_config.sv
// Self-checking bench for the event routing and configuration block
`timescale 1ns/1ps
module test_pmic_event_routing_config;
	localparam logic [6:0] ADDR = 7'h2A; // Arbitrary device address
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic scl, sda_pull, sda, sda_oe, irq_n, pg, sev, med, std, tdie;
	logic sdo;
	logic [10:0] gpio, pto, e;
	logic [9:0] rf, uv, ov;
	logic [1:0] rst2;
	logic [3:0] trq;
	logic [pmer_pkg::NEV-1:0] ev;
	logic [pmer_pkg::NREG-1:0][7:0] mdl;
	logic [7:0] d;
	logic [4:0] s;
	logic [31:0] r;
	logic [4:0] steps [5] = '{5'h02, 5'h06, 5'h05, 5'h0D, 5'h1D};
	integer seed = 32'h8916_84ff;
	int bad_count = 0;
	int compares = 0;
	int c, t;
	// Open-drain data line with pull-up
	assign sda = !(sda_pull || sda_oe);
	// Clock
	always #50 clk = ~clk;
	pmer_top #(.DEV_ADDR(ADDR)) dut (.clk(clk), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe),
		.gpio_pin(gpio), .rail_fault(rf), .severe_fault(sev),
		.medium_fault(med), .self_test_done(std), .irq_event(ev),
		.mon_uv_ok(uv), .mon_ov_ok(ov), .tdie_ok(tdie),
		.rst_out_ok(rst2), .interrupt_request_pin_n(irq_n),
		.power_good_output(pg), .pin_trigger_out(pto),
		.trigger_req(trq));
	pmer_host #(.ADDR(ADDR)) h (.clk(clk), .sda(sda), .scl(scl),
		.sda_pull(sda_pull));
	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic chk(input string n, input logic [7:0] x,
		input logic [7:0] g);
		compares++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// One-cycle pulse on a fault or event input
	task automatic fire(input int k, input int b);
		@(negedge clk);
		case (k)
			0: rf[b] = 1'b1;
			1: sev = 1'b1;
			2: med = 1'b1;
			3: std = 1'b1;
			default: ev[b] = 1'b1;
		endcase
		@(negedge clk);
		rf = '0;
		ev = '0;
		{sev, med, std} = 3'h0;
	endtask : fire
	task automatic do_reset;
		@(negedge clk);
		resetn = 1'b0;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		mdl = pmer_pkg::RST_VAL;
		tick(4);
		chk("idle irq", 8'h01, {7'h00, irq_n});
		chk("data drive", 8'h00, {7'h00, sdo});
	endtask : do_reset
	task automatic complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// Watchdog against a hung link
	initial begin
		repeat (99000) @(posedge clk);
		bad_count++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{gpio, rf, ev, sev, med, std} = '0;
		uv = '1;
		ov = '1;
		tdie = 1'b1;
		rst2 = 2'h3;
		do_reset();
		for (int i = 0; i < 30; i++) begin
			h.rd(8'(i), d);
			chk("reset value", (i < 29) ? mdl[i] : 8'h00, d);
		end
		for (int i = 0; i < 29; i++) begin
			r = $random(seed);
			h.wr(8'(i), r[7:0]);
			mdl[i] = r[7:0] & pmer_pkg::WR_MASK[i];
			h.rd(8'(i), d);
			chk("read back", mdl[i], d);
		end
		$display("test registers done");
		// Group, severe and medium routing; last pass remaps the SOC group
		do_reset();
		for (int i = 0; i < 5; i++) begin
			c = (i == 4) ? 2 : i;
			mdl[0][1:0] = 2'(c);
			mdl[3][7:6] = 2'(c);
			mdl[4][1:0] = 2'(c);
			if (i == 4)
				mdl[3][3:2] = pmer_pkg::TRG_MCU;
			h.wr(pmer_pkg::R_RAIL_A, mdl[0]);
			h.wr(pmer_pkg::R_TRIG_A, mdl[3]);
			h.wr(pmer_pkg::R_TRIG_B, mdl[4]);
			t = (c == 1) ? mdl[3][1:0] : (c == 2) ? mdl[3][3:2] : mdl[3][5:4];
			fire(0, 0);
			chk("rail trigger", 8'(4'h1 << t), {4'h0, trq});
			fire(1, 0);
			chk("severe trigger", 8'(4'h1 << c), {4'h0, trq});
			fire(2, 0);
			chk("medium trigger", 8'(4'h1 << c), {4'h0, trq});
			tick(2);
			chk("fault irq", 8'h00, {7'h00, irq_n});
			h.wr(8'h2C, 8'h0F);
			tick(2);
			chk("irq cleared", 8'h01, {7'h00, irq_n});
		end
		$display("test triggers done");
		// One event with its mask clear, then set
		r = $random(seed);
		c = int'(r[7:0]) % 6;
		for (int m = 0; m < 2; m++) begin
			h.wr(pmer_pkg::R_SW_A, 8'(m << c));
			fire(4, c);
			tick(1);
			chk("event irq", 8'(m), {7'h00, irq_n});
			h.rd(8'h20, d);
			chk("pending", 8'(1 << c), d);
			chk("irq held", 8'(m), {7'h00, irq_n});
			h.wr(8'h20, 8'(1 << c));
			tick(2);
			chk("irq cleared", 8'h01, {7'h00, irq_n});
		end
		// Self test end opens the supply voltage interrupts
		fire(3, 0);
		h.rd(pmer_pkg::R_SUPMON, d);
		chk("supply mask", 8'h00, d);
		fire(4, pmer_pkg::EV_FALL - 8 + pmer_pkg::SUP_UV_BIT);
		tick(1);
		chk("supply irq", 8'h00, {7'h00, irq_n});
		h.wr(8'h25, 8'h03);
		$display("test masks done");
		// Pin gating: defaults, open, forced high
		r = $random(seed);
		gpio = r[10:0];
		for (int g = 0; g < 3; g++) begin
			if (g > 0)
				for (int k = 0; k < 3; k++)
					h.wr(8'(pmer_pkg::R_GATE_A + k), (g == 1) ? 8'h00 : 8'hFF);
			tick(4);
			e = (g == 0) ? 11'h000 : (g == 1) ? gpio : 11'h7FF;
			chk("pins low", e[7:0], pto[7:0]);
			chk("pins high", {5'h00, e[10:8]}, {5'h00, pto[10:8]});
		end
		// Rising edge unmasked, falling edge masked on the first pin
		gpio[0] = 1'b0;
		h.wr(8'h27, 8'hFF);
		h.wr(pmer_pkg::R_RISE, 8'hFE);
		chk("edge idle", 8'h01, {7'h00, irq_n});
		gpio[0] = 1'b1;
		tick(5);
		chk("rise irq", 8'h00, {7'h00, irq_n});
		h.wr(8'h27, 8'h01);
		gpio[0] = 1'b0;
		tick(5);
		chk("fall masked", 8'h01, {7'h00, irq_n});
		$display("test pins done");
		// Power good: select, window and polarity steps on the first rail
		for (int i = 0; i < 5; i++) begin
			s = steps[i];
			uv[0] = s[0];
			ov[0] = s[1];
			h.wr(pmer_pkg::R_PG_A, {7'h00, s[2]});
			// Window mode on bit 5, polarity on bit 4
			h.wr(pmer_pkg::R_PG_D, {2'h0, s[3], s[4], 4'h0});
			tick(4);
			t = int'(!s[2] || (s[0] && (!s[3] || s[1]))) ^ int'(s[4]);
			chk("power good", 8'(t), {7'h00, pg});
		end
		// Die warning selected together with the first rail, which is still valid
		tdie = 1'b0;
		h.wr(pmer_pkg::R_PG_D, 8'h02);
		tick(4);
		chk("die source", 8'h00, {7'h00, pg});
		$display("test power good done");
		complete_run();
	end
endmodule : test_pmic_event_routing_config
